// ==== src/ifc_pkg.sv ====
// package for the in-band flow control block: register map, fields,
// commands, reset values and the state types of every module.
// assumes a single 20 MHz system clock and a 32-bit word-wide register bus.
package ifc_pkg;

  // ----------------------------------------------------------------
  // register word indices, byte address is index times four
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_MODE = 6'h00;
  localparam logic [5:0] IDX_CMD = 6'h01;
  localparam logic [5:0] IDX_RES_CH = 6'h02;
  localparam logic [5:0] IDX_PAU_CH = 6'h03;
  localparam logic [5:0] IDX_IMR = 6'h04;
  localparam logic [5:0] IDX_ISR = 6'h05;
  localparam logic [5:0] IDX_XSTAT = 6'h06;
  localparam logic [5:0] IDX_BID = 6'h07;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned MR0_AUTO_TX = 2;
  localparam int unsigned MR0_AUTO_RX = 3;
  localparam int unsigned MR0_TRANSP = 7;
  localparam int unsigned IMR_FLOW_MASK = 4;
  localparam int unsigned ISR_FLOW = 4;
  localparam int unsigned CMD_LSB = 3;
  localparam int unsigned CMD_MSB = 7;

  // ----------------------------------------------------------------
  // command codes in command field
  // ----------------------------------------------------------------
  localparam logic [4:0] CMD_RESUME_TX = 5'h16;
  localparam logic [4:0] CMD_PAUSE_TX = 5'h15;
  localparam logic [4:0] CMD_SEND_RES = 5'h18;
  localparam logic [4:0] CMD_SEND_PAU = 5'h19;
  localparam logic [4:0] CMD_CANCEL = 5'h1a;
  localparam logic [4:0] CMD_SOFT_RST = 5'h1b;

  // ----------------------------------------------------------------
  // thresholds, reset values, bus codes
  // ----------------------------------------------------------------
  localparam logic [4:0] RX_PAUSE_LVL = 5'h0c;
  localparam logic [4:0] RX_RESUME_LVL = 5'h08;
  localparam logic [7:0] MR0_RESET = 8'h00;
  localparam logic [7:0] IMR_RESET = 8'h00;
  localparam logic [2:0] BID_RESET = 3'h0;
  localparam logic [7:0] CHAR_RESET = 8'h00;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ----------------------------------------------------------------
  // carrier and state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pause;
    logic resume;
  } ifc_flow_req_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_SENT = 2'h1
  } ifc_tx_fsm_t;

  typedef struct packed {
    ifc_tx_fsm_t fsm;
    logic load;
    logic pop;
    logic [7:0] data;
    ifc_flow_req_t sent;
  } ifc_tx_st_t;

  typedef struct packed {
    logic [7:0] mr0;
    logic [7:0] interrupt_mask_register;
    logic [2:0] bid;
    logic [7:0] res_ch;
    logic [7:0] pau_ch;
    logic recog_en;
    logic host_halt;
    logic auto_halt;
    logic halt;
    logic pend_res;
    logic pend_pau;
    logic sent_pau;
    logic evt_pend;
    logic evt_res;
    logic evt_pau;
    logic ph_vld;
    logic ph_wr;
    logic [5:0] ph_idx;
    logic [31:0] rdata;
    logic hready;
    logic push;
    logic [7:0] push_data;
    logic irq;
  } ifc_top_st_t;

endpackage

// ==== src/ifc_char_match.sv ====
// two character comparators: entry 0 resume, entry 1 pause.
// assumes the received character and references are stable in the cycle.
`timescale 1ns/1ps
module ifc_char_match import ifc_pkg::*; (
  input wire logic [7:0] char_in,
  input wire logic [1:0][7:0] ref_in,
  output logic [1:0] hit_out
);

  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  // one comparator per reference, run in every mode
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    assign hit_out[i] = (char_in == ref_in[i]);
  end

endmodule

// ==== src/ifc_tx_insert.sv ====
// transmit loader: places flow characters between transmit fifo characters.
// assumes the shifter drops shift_ready_in the cycle after a load.
`timescale 1ns/1ps
module ifc_tx_insert import ifc_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic shift_ready_in,
  input wire logic halt_in,
  input wire logic fifo_valid_in,
  input wire logic [7:0] fifo_data_in,
  input wire ifc_flow_req_t req_in,
  input wire logic [7:0] res_char_in,
  input wire logic [7:0] pau_char_in,
  output logic pop_out,
  output logic load_out,
  output logic [7:0] data_out,
  output ifc_flow_req_t sent_out
);

  ifc_tx_st_t st_q;
  ifc_tx_st_t st_d;

  // ----------------------------------------------------------------
  // loader
  // ----------------------------------------------------------------
  // flow characters outrank fifo data and ignore the halt
  always_comb begin
    st_d = st_q;
    st_d.load = 1'b0;
    st_d.pop = 1'b0;
    st_d.sent = '0;
    unique case (st_q.fsm)
      TX_IDLE: begin
        if (shift_ready_in) begin
          if (req_in.pause) begin
            st_d.data = pau_char_in;
            st_d.load = 1'b1;
            st_d.sent.pause = 1'b1;
            st_d.fsm = TX_SENT;
          end else if (req_in.resume) begin
            st_d.data = res_char_in;
            st_d.load = 1'b1;
            st_d.sent.resume = 1'b1;
            st_d.fsm = TX_SENT;
          end else if (fifo_valid_in && !halt_in) begin
            st_d.data = fifo_data_in;
            st_d.load = 1'b1;
            st_d.pop = 1'b1;
            st_d.fsm = TX_SENT;
          end
        end
      end
      // a loaded character is never recalled, only reset stops it
      TX_SENT: st_d.fsm = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_q <= '{fsm: TX_IDLE, data: 8'h00, sent: '0, default: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign pop_out = st_q.pop;
  assign load_out = st_q.load;
  assign data_out = st_q.data;
  assign sent_out = st_q.sent;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  halt_no_pop_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    halt_in |=> !pop_out) else $error("fifo popped while halted");

endmodule

// ==== src/ifc_flow_ctrl.sv ====
// in-band flow control of one uart channel, with its ahb-lite registers.
// assumes receiver, fifos and shifter sit outside and run on clk_sys_in.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ifc_flow_ctrl import ifc_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic rx_char_valid_in,
  input wire logic [7:0] rx_char_in,
  input wire logic rx_fifo_room_in,
  input wire logic [4:0] rx_fifo_level_in,
  output logic rx_push_out,
  output logic [7:0] rx_push_data_out,
  input wire logic tx_fifo_valid_in,
  input wire logic [7:0] tx_fifo_data_in,
  input wire logic tx_shift_ready_in,
  output logic tx_fifo_pop_out,
  output logic tx_load_out,
  output logic [7:0] tx_load_data_out,
  output logic tx_halted_out,
  output logic flow_irq_req_out,
  output logic [2:0] flow_irq_bid_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ifc_top_st_t st_q;
  ifc_top_st_t st_d;
  logic [1:0] match;
  logic hit;
  logic host;
  logic cmd_wr;
  logic [4:0] cmd;
  logic acc;
  logic xst_rd;
  logic want_pau;
  logic want_res;
  ifc_flow_req_t flow_req;
  ifc_flow_req_t tx_sent;

  localparam ifc_top_st_t ST_RESET = '{
    mr0: MR0_RESET,
    interrupt_mask_register: IMR_RESET,
    bid: BID_RESET,
    res_ch: CHAR_RESET,
    pau_ch: CHAR_RESET,
    ph_idx: 6'h00,
    rdata: 32'h0000_0000,
    hready: 1'b1,
    push_data: 8'h00,
    default: 1'b0
  };

  // ----------------------------------------------------------------
  // register read view
  // ----------------------------------------------------------------
  function automatic logic [31:0] rd_word(input ifc_top_st_t s, input logic [5:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (idx)
      IDX_MODE: w = {24'h00_0000, s.mr0};
      IDX_RES_CH: w = {24'h00_0000, s.res_ch};
      IDX_PAU_CH: w = {24'h00_0000, s.pau_ch};
      IDX_IMR: w = {24'h00_0000, s.interrupt_mask_register};
      IDX_ISR: w = 32'(s.evt_pend) << ISR_FLOW;
      // details plus non-interrupting flow state
      IDX_XSTAT: w = {27'h000_0000, s.pend_res | s.pend_pau, s.halt,
                      s.sent_pau, s.evt_pau, s.evt_res};
      IDX_BID: w = {29'h0000_0000, s.bid};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // decode terms
  // ----------------------------------------------------------------
  // comparators see every character, whatever the mode field holds
  ifc_char_match u_match (
    .char_in(rx_char_in),
    .ref_in({st_q.pau_ch, st_q.res_ch}),
    .hit_out(match)
  );

  // recognition needs fifo room, so an overrun character does nothing
  assign hit = rx_char_valid_in && rx_fifo_room_in && st_q.recog_en && (|match);
  assign host = (st_q.mr0[MR0_AUTO_RX:MR0_AUTO_TX] == 2'h0);
  assign cmd_wr = st_q.ph_vld && st_q.ph_wr && (st_q.ph_idx == IDX_CMD);
  assign cmd = hwdata_in[CMD_MSB:CMD_LSB];
  assign acc = hsel_in && hready_in && htrans_in[1] && (hsize_in == HSIZE_WORD);
  assign xst_rd = acc && !hwrite_in && (haddr_in[7:2] == IDX_XSTAT);

  // fill thresholds; a request vanishing before load is never sent
  assign want_pau = st_q.mr0[MR0_AUTO_RX] && (rx_fifo_level_in > RX_PAUSE_LVL) &&
                    !st_q.sent_pau;
  assign want_res = st_q.mr0[MR0_AUTO_RX] && (rx_fifo_level_in < RX_RESUME_LVL) &&
                    st_q.sent_pau;
  assign flow_req.pause = st_q.pend_pau || want_pau;
  assign flow_req.resume = st_q.pend_res || want_res;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.push = 1'b0;
    st_d.hready = 1'b1;

    // register writes land in the data phase
    if (st_q.ph_vld && st_q.ph_wr) begin
      unique case (st_q.ph_idx)
        IDX_MODE: st_d.mr0 = hwdata_in[7:0];
        IDX_IMR: st_d.interrupt_mask_register = hwdata_in[7:0];
        IDX_BID: st_d.bid = hwdata_in[2:0];
        IDX_RES_CH: begin
          st_d.res_ch = hwdata_in[7:0];
          st_d.recog_en = 1'b1;
        end
        IDX_PAU_CH: begin
          st_d.pau_ch = hwdata_in[7:0];
          st_d.recog_en = 1'b1;
        end
        // commands other than soft reset touch the flow logic only in host mode
        IDX_CMD: if (host) begin
          unique case (cmd)
            CMD_PAUSE_TX: st_d.host_halt = 1'b1;
            CMD_RESUME_TX: st_d.host_halt = 1'b0;
            // setting an already pending request changes nothing
            CMD_SEND_RES: begin
              st_d.pend_res = 1'b1;
              st_d.pend_pau = 1'b0;
            end
            CMD_SEND_PAU: begin
              st_d.pend_pau = 1'b1;
              st_d.pend_res = 1'b0;
            end
            // only pending requests go; a loaded character is untouched
            CMD_CANCEL: begin
              st_d.pend_res = 1'b0;
              st_d.pend_pau = 1'b0;
            end
            default: st_d.host_halt = st_q.host_halt;
          endcase
        end
        default: st_d.mr0 = st_q.mr0;
      endcase
    end

    // address phase of the bus, read data prepared one cycle ahead
    st_d.ph_vld = acc;
    st_d.ph_wr = hwrite_in;
    st_d.ph_idx = haddr_in[7:2];
    st_d.rdata = (acc && !hwrite_in) ? rd_word(st_d, haddr_in[7:2]) : 32'h0000_0000;
    if (xst_rd) begin
      st_d.evt_pend = 1'b0;
      st_d.evt_res = 1'b0;
      st_d.evt_pau = 1'b0;
    end

    // receive path; comes after the clear so a new event wins
    if (rx_char_valid_in && rx_fifo_room_in && !(hit && st_q.mr0[MR0_TRANSP])) begin
      st_d.push = 1'b1;
      st_d.push_data = rx_char_in;
    end
    if (hit) begin
      st_d.evt_pend = 1'b1;
      st_d.evt_res = st_d.evt_res | match[0];
      st_d.evt_pau = st_d.evt_pau | match[1];
    end

    // received characters gate the transmitter in auto transmit mode
    if (st_q.mr0[MR0_AUTO_TX] && hit) begin
      st_d.auto_halt = match[1] ? 1'b1 : 1'b0;
    end
    if (!st_d.mr0[MR0_AUTO_TX]) begin
      st_d.auto_halt = 1'b0;
    end

    // sent characters retire requests and no event is raised for them;
    // a send command landing with the sent pulse stays pending, set wins
    if (tx_sent.pause) begin
      st_d.pend_pau = cmd_wr && host && (cmd == CMD_SEND_PAU);
      st_d.sent_pau = st_q.mr0[MR0_AUTO_RX];
    end
    if (tx_sent.resume) begin
      st_d.pend_res = cmd_wr && host && (cmd == CMD_SEND_RES);
      st_d.sent_pau = 1'b0;
    end
    // leaving auto receive forgets the unanswered pause
    if (!st_d.mr0[MR0_AUTO_RX]) begin
      st_d.sent_pau = 1'b0;
    end

    // software reset: recognition off, flow state back to idle
    if (cmd_wr && cmd == CMD_SOFT_RST) begin
      st_d.mr0 = MR0_RESET;
      st_d.recog_en = 1'b0;
      st_d.host_halt = 1'b0;
      st_d.auto_halt = 1'b0;
      st_d.pend_res = 1'b0;
      st_d.pend_pau = 1'b0;
      st_d.sent_pau = 1'b0;
      st_d.evt_pend = 1'b0;
      st_d.evt_res = 1'b0;
      st_d.evt_pau = 1'b0;
    end

    // host halt survives resume characters and enable changes
    st_d.halt = st_d.host_halt | st_d.auto_halt;
    st_d.irq = st_d.evt_pend && !st_d.interrupt_mask_register[IMR_FLOW_MASK];
  end

  // mode bits and recognition start cleared
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // transmit loader
  // ----------------------------------------------------------------
  ifc_tx_insert u_tx (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .shift_ready_in(tx_shift_ready_in),
    .halt_in(st_q.halt),
    .fifo_valid_in(tx_fifo_valid_in),
    .fifo_data_in(tx_fifo_data_in),
    .req_in(flow_req),
    .res_char_in(st_q.res_ch),
    .pau_char_in(st_q.pau_ch),
    .pop_out(tx_fifo_pop_out),
    .load_out(tx_load_out),
    .data_out(tx_load_data_out),
    .sent_out(tx_sent)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output but hresp_out, tied low, and the three tx outputs driven by u_tx is a flop of the state record
  assign hreadyout_out = st_q.hready;
  assign hresp_out = 1'b0;
  assign hrdata_out = st_q.rdata;
  assign rx_push_out = st_q.push;
  assign rx_push_data_out = st_q.push_data;
  assign tx_halted_out = st_q.halt;
  assign flow_irq_req_out = st_q.irq;
  assign flow_irq_bid_out = st_q.bid;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  mode_reset_zero_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> st_q.mr0[MR0_AUTO_RX:MR0_AUTO_TX] == 2'h0)
    else $error("flow mode not cleared by reset");

  host_pause_halt_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    host && cmd_wr && cmd == CMD_PAUSE_TX |=> tx_halted_out)
    else $error("pause command did not halt");

  host_halt_hold_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    st_q.host_halt && !cmd_wr |=> st_q.host_halt)
    else $error("host halt lifted without command");

  cancel_auto_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !host && cmd_wr && cmd == CMD_CANCEL && st_q.pend_res && !tx_sent.resume
    |=> st_q.pend_res)
    else $error("cancel acted in automatic mode");

  transp_withhold_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    hit && st_q.mr0[MR0_TRANSP] |=> !rx_push_out)
    else $error("flow character pushed while transparent");

  normal_push_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    rx_char_valid_in && rx_fifo_room_in && !hit
    |=> rx_push_out && rx_push_data_out == $past(rx_char_in))
    else $error("ordinary character not pushed");

  irq_masked_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    st_q.interrupt_mask_register[IMR_FLOW_MASK] |-> !flow_irq_req_out)
    else $error("masked flow event raised request");

  event_cause_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    $rose(st_q.evt_pend) |-> $past(hit))
    else $error("flow event without matching character");

  status_clear_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    xst_rd && !hit ##1 !hit |-> !st_q.evt_pend && !flow_irq_req_out)
    else $error("event not cleared by status read");

  send_cancel_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    host && cmd_wr && cmd == CMD_SEND_RES |=> st_q.pend_res && !st_q.pend_pau)
    else $error("send resume did not replace pending pause");

  cancel_host_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    host && cmd_wr && cmd == CMD_CANCEL |=> !st_q.pend_res && !st_q.pend_pau)
    else $error("cancel left a send pending");

  soft_reset_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    cmd_wr && cmd == CMD_SOFT_RST |=> !st_q.recog_en && !tx_halted_out && !flow_irq_req_out)
    else $error("soft reset left recognition or halt active");

endmodule

// ==== testbench/ifc_far_model.sv ====
// far side model: the transmit shifter and the transmit fifo of the channel.
// assumes loads and pops come from the block as one-cycle register pulses.
`timescale 1ns/1ps
module ifc_far_model (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic load_in,
  input wire logic [7:0] load_data_in,
  input wire logic pop_in,
  input wire logic add_in,
  input wire logic slow_in,
  output logic shift_ready_out,
  output logic fifo_valid_out,
  output logic [7:0] fifo_data_out,
  output logic [7:0] last_out,
  output logic [7:0] nload_out
);
  logic [5:0] busy_q;
  logic [3:0] cnt_q;
  logic [7:0] head_q;

  // ----------------------------------------------------------------
  // shifter and fifo
  // ----------------------------------------------------------------
  // a loaded character always runs its full time, no abort path
  assign shift_ready_out = (busy_q == 6'h00);
  assign fifo_valid_out = (cnt_q != 4'h0);
  // an empty fifo shows a moving pattern, so a stale head cannot pass as data
  assign fifo_data_out = fifo_valid_out ? head_q : (~head_q ^ nload_out);

  // slow mode keeps the shifter busy long enough to stack commands behind it
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      busy_q <= 6'h00;
      cnt_q <= 4'h0;
      head_q <= 8'h30;
      last_out <= 8'h00;
      nload_out <= 8'h00;
    end else begin
      if (load_in) begin
        busy_q <= slow_in ? 6'h28 : 6'h03;
        last_out <= load_data_in;
        nload_out <= nload_out + 8'h01;
      end else if (busy_q != 6'h00) begin
        busy_q <= busy_q - 6'h01;
      end
      if (pop_in) begin
        head_q <= head_q + 8'h01;
      end
      cnt_q <= cnt_q + {3'h0, add_in} - {3'h0, pop_in};
    end
  end
endmodule

// ==== testbench/inband_flow_control_logic_tb.sv ====
// testbench for the flow control block: register rows, events, halts, sends.
// assumes the far model stands in for the shifter and the transmit fifo.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h got %h", n, e, g); end end
module inband_flow_control_logic_tb;
  import ifc_pkg::*;
  typedef struct packed {logic [5:0] idx; logic [31:0] wd; logic [31:0] ev;} ifc_row_t;
  localparam ifc_row_t ROWS [9] = '{'{IDX_RES_CH, 32'h11, 32'h11},
    '{IDX_PAU_CH, 32'h13, 32'h13}, '{IDX_BID, 32'h05, 32'h05}, '{IDX_IMR, 32'h10, 32'h10},
    '{IDX_IMR, 32'h00, 32'h00}, '{IDX_MODE, 32'h80, 32'h80}, '{IDX_MODE, 32'h00, 32'h00},
    '{IDX_CMD, 32'h00, 32'h00}, '{6'h20, 32'h5a, 32'h00}};
  int err_count = 0;
  int num_checks = 0;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic rxv = 1'b0;
  logic [7:0] rxc = 8'h00;
  logic room = 1'b1;
  logic [4:0] lvl = 5'h00;
  logic add = 1'b0;
  logic slow = 1'b0;
  logic hreadyout, hresp, push, fv, rdy, pop, ld, halted, irq, got_push;
  logic [31:0] hrdata;
  logic [7:0] pushd, fd, ldd, last, nload, got_pd;
  logic [2:0] bid;

  always #25 clk_sys_in = ~clk_sys_in;

  ifc_flow_ctrl dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hreadyout), .hreadyout_out(hreadyout),
    .hresp_out(hresp), .hrdata_out(hrdata), .rx_char_valid_in(rxv), .rx_char_in(rxc),
    .rx_fifo_room_in(room), .rx_fifo_level_in(lvl), .rx_push_out(push),
    .rx_push_data_out(pushd), .tx_fifo_valid_in(fv), .tx_fifo_data_in(fd),
    .tx_shift_ready_in(rdy), .tx_fifo_pop_out(pop), .tx_load_out(ld),
    .tx_load_data_out(ldd), .tx_halted_out(halted), .flow_irq_req_out(irq),
    .flow_irq_bid_out(bid));

  ifc_far_model far (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .load_in(ld),
    .load_data_in(ldd), .pop_in(pop), .add_in(add), .slow_in(slow),
    .shift_ready_out(rdy), .fifo_valid_out(fv), .fifo_data_out(fd), .last_out(last),
    .nload_out(nload));

  // ----------------------------------------------------------------
  // bus and line tasks
  // ----------------------------------------------------------------
  // address phase held until hready, then data phase held until hready
  task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {idx, 2'h0};
    hwrite <= w;
    hsize <= HSIZE_WORD;
    @(posedge clk_sys_in);
    while (hreadyout !== 1'b1) @(posedge clk_sys_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys_in);
    while (hreadyout !== 1'b1) @(posedge clk_sys_in);
    rd = hrdata;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, idx, d, v);
  endtask

  task automatic chk_rd(input logic [5:0] idx, input logic [31:0] ev, input string nm);
    logic [31:0] v;
    bus(1'b0, idx, 32'h0, v);
    `CHK(nm, ev, v)
  endtask

  function automatic logic [31:0] cw(input logic [4:0] c);
    return {24'h0, c, 3'h0};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  // one received character; the push is looked at in the cycle after the character
  task automatic rx(input logic [7:0] c, input logic rm);
    rxv <= 1'b1;
    rxc <= c;
    room <= rm;
    @(posedge clk_sys_in);
    rxv <= 1'b0;
    room <= 1'b1;
    #1;
    got_push = push;
    got_pd = pushd;
    @(posedge clk_sys_in);
  endtask

  task automatic tally_and_finish;
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [7:0] n0;
    cyc(8);
    sys_rst_in <= 1'b0;
    cyc(2);
    chk_rd(IDX_MODE, 32'h0, "mode reset");
    chk_rd(IDX_ISR, 32'h0, "isr reset");
    `CHK("halted reset", 1'b0, halted)
    foreach (ROWS[i]) begin
      wr(ROWS[i].idx, ROWS[i].wd);
      chk_rd(ROWS[i].idx, ROWS[i].ev, "register row");
    end
    `CHK("bid", 3'h5, bid)
    `CHK("hresp", 1'b0, hresp)
    // recognition, status, clear on read, mask
    rx(8'h11, 1'b1);
    `CHK("push", 1'b1, got_push)
    `CHK("push data", 8'h11, got_pd)
    cyc(2);
    `CHK("irq", 1'b1, irq)
    chk_rd(IDX_ISR, 32'h10, "isr event");
    chk_rd(IDX_XSTAT, 32'h1, "xstat resume");
    cyc(2);
    chk_rd(IDX_ISR, 32'h0, "isr cleared");
    `CHK("irq cleared", 1'b0, irq)
    rx(8'h55, 1'b1);
    chk_rd(IDX_ISR, 32'h0, "no match");
    wr(IDX_IMR, 32'h10);
    rx(8'h13, 1'b1);
    cyc(2);
    `CHK("irq masked", 1'b0, irq)
    chk_rd(IDX_XSTAT, 32'h2, "xstat pause");
    wr(IDX_IMR, 32'h0);
    // transparency in host and auto transmit modes
    wr(IDX_MODE, 32'h80);
    rx(8'h11, 1'b1);
    `CHK("withheld", 1'b0, got_push)
    wr(IDX_MODE, 32'h84);
    rx(8'h13, 1'b1);
    `CHK("withheld auto", 1'b0, got_push)
    cyc(2);
    `CHK("auto halt", 1'b1, halted)
    rx(8'h11, 1'b1);
    cyc(2);
    `CHK("auto resume", 1'b0, halted)
    rx(8'h13, 1'b0);
    cyc(2);
    `CHK("overrun ignored", 1'b0, halted)
    wr(IDX_CMD, cw(CMD_PAUSE_TX));
    cyc(2);
    `CHK("cmd in auto", 1'b0, halted)
    wr(IDX_MODE, 32'h0);
    bus(1'b0, IDX_XSTAT, 32'h0, v);
    // host halt and resume
    n0 = nload;
    add <= 1'b1;
    cyc(2);
    add <= 1'b0;
    cyc(20);
    `CHK("fifo loads", n0 + 8'h02, nload)
    wr(IDX_CMD, cw(CMD_PAUSE_TX));
    cyc(2);
    `CHK("host halt", 1'b1, halted)
    n0 = nload;
    add <= 1'b1;
    cyc(1);
    add <= 1'b0;
    rx(8'h11, 1'b1);
    cyc(20);
    `CHK("still halted", 1'b1, halted)
    `CHK("no load", n0, nload)
    bus(1'b0, IDX_XSTAT, 32'h0, v);
    wr(IDX_CMD, cw(CMD_RESUME_TX));
    cyc(20);
    `CHK("resumed", n0 + 8'h01, nload)
    `CHK("fifo char", 8'h32, last)
    wr(IDX_CMD, cw(CMD_SEND_RES));
    cyc(20);
    `CHK("resume char", 8'h11, last)
    chk_rd(IDX_ISR, 32'h0, "no tx event");
    // commands stacked behind a busy shifter
    slow <= 1'b1;
    add <= 1'b1;
    cyc(1);
    add <= 1'b0;
    cyc(3);
    n0 = nload;
    wr(IDX_CMD, cw(CMD_SEND_PAU));
    wr(IDX_CMD, cw(CMD_CANCEL));
    bus(1'b0, IDX_XSTAT, 32'h0, v);
    `CHK("pending dropped", 1'b0, v[4])
    cyc(60);
    `CHK("nothing sent", n0, nload)
    add <= 1'b1;
    cyc(1);
    add <= 1'b0;
    cyc(3);
    wr(IDX_CMD, cw(CMD_SEND_PAU));
    wr(IDX_CMD, cw(CMD_SEND_RES));
    wr(IDX_CMD, cw(CMD_SEND_RES));
    cyc(100);
    `CHK("one flow char", n0 + 8'h02, nload)
    `CHK("resume wins", 8'h11, last)
    // a send left pending survives a cancel once an automatic mode is on
    add <= 1'b1;
    cyc(1);
    add <= 1'b0;
    cyc(3);
    n0 = nload;
    wr(IDX_CMD, cw(CMD_SEND_RES));
    wr(IDX_MODE, 32'h04);
    wr(IDX_CMD, cw(CMD_CANCEL));
    bus(1'b0, IDX_XSTAT, 32'h0, v);
    `CHK("cancel in auto", 1'b1, v[4])
    cyc(100);
    `CHK("kept send", n0 + 8'h01, nload)
    slow <= 1'b0;
    // automatic receive thresholds
    n0 = nload;
    wr(IDX_MODE, 32'h08);
    lvl <= 5'd12;
    cyc(20);
    `CHK("level 12", n0, nload)
    lvl <= 5'd13;
    cyc(20);
    `CHK("pause sent", 8'h13, last)
    lvl <= 5'd8;
    cyc(20);
    `CHK("level 8", n0 + 8'h01, nload)
    lvl <= 5'd7;
    cyc(20);
    `CHK("resume sent", 8'h11, last)
    `CHK("level 7", n0 + 8'h02, nload)
    lvl <= 5'd0;
    // soft reset, then a hard reset in mid-run
    wr(IDX_CMD, cw(CMD_SOFT_RST));
    chk_rd(IDX_MODE, 32'h0, "mode soft");
    rx(8'h11, 1'b1);
    chk_rd(IDX_ISR, 32'h0, "recog off");
    wr(IDX_RES_CH, 32'h11);
    sys_rst_in <= 1'b1;
    cyc(2);
    sys_rst_in <= 1'b0;
    cyc(2);
    rx(8'h11, 1'b1);
    chk_rd(IDX_ISR, 32'h0, "recog off hard");
    tally_and_finish();
  end

  // watchdog well beyond the several hundred cycles the sequence needs
  initial begin
    cyc(20000);
    err_count++;
    tally_and_finish();
  end
endmodule
